// File: ssp_pkg.sv
/*
 * shared constants, types and helpers of the serial port block:
 * register offsets, field positions, mode codes, rate counts.
 * assumes a 20 MHz system clock and byte-wide register data.
 */
package ssp_pkg;
	localparam logic [7:0] OFS_BUFFER = 8'h10;
	localparam logic [7:0] OFS_CONTROL = 8'h14;
	localparam logic [7:0] OFS_IRQ = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h94;

	localparam int CTL_WRITE_COLLISION_FLAG = 7;
	localparam int CTL_OV = 6;
	localparam int CTL_EN = 5;
	localparam int CTL_CKP = 4;
	localparam int CTL_MODE_MSB = 3;
	localparam int STS_BF = 0;
	localparam int IRQ_FLAG = 0;
	localparam int SHIFT_MSB = 7;

	localparam logic [3:0] MODE_M4 = 4'h0;
	localparam logic [3:0] MODE_M16 = 4'h1;
	localparam logic [3:0] MODE_M64 = 4'h2;
	localparam logic [3:0] MODE_MTMR = 4'h3;
	localparam logic [3:0] MODE_SL_SS = 4'h4;
	localparam logic [3:0] MODE_SL = 4'h5;

	localparam logic [1:0] RATE_M16 = 2'h1;
	localparam logic [1:0] RATE_M64 = 2'h2;
	localparam logic [1:0] RATE_TMR = 2'h3;
	// half serial clock period in system clocks
	localparam logic [5:0] HALF_DIV4 = 6'h02;
	localparam logic [5:0] HALF_DIV16 = 6'h08;
	localparam logic [5:0] HALF_DIV64 = 6'h20;
	localparam logic [2:0] LAST_BIT = 3'h7;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum logic [1:0] {
		MS_IDLE = 2'b00,
		MS_LEAD = 2'b01,
		MS_TRAIL = 2'b10
	} ssp_mst_t;

	typedef enum logic [1:0] {
		AP_IDLE = 2'b00,
		AP_WR = 2'b01,
		AP_RD = 2'b10,
		AP_RDOUT = 2'b11
	} ssp_aph_t;

	typedef struct packed {
		ssp_aph_t ph;
		logic [7:0] addr;
		logic [31:0] rdata;
	} ssp_ahb_t;

	typedef struct packed {
		logic [5:0] cnt;
	} ssp_rate_t;

	typedef struct packed {
		logic write_collision_flag;
		logic ov;
		logic en;
		logic clock_polarity_bit;
		logic [3:0] mode;
		logic bf;
		logic irq;
		logic [7:0] rxBuf;
		logic [7:0] shreg;
		logic [2:0] bitCnt;
		ssp_mst_t mst;
		logic sckAct;
		logic outBit;
		logic sckPrev;
	} ssp_core_t;

	function automatic logic isMaster(input logic [3:0] m);
		return (m == MODE_M4) || (m == MODE_M16) ||
			(m == MODE_M64) || (m == MODE_MTMR);
	endfunction

	function automatic logic isSlave(input logic [3:0] m);
		return (m == MODE_SL_SS) || (m == MODE_SL);
	endfunction
endpackage

// File: ssp_reg_if.sv
`timescale 1ns/1ps
/*
 * register access strobes between the bus slave and the core.
 * assumes strobes last one clock and rdata is combinational.
 */
interface ssp_reg_if;
	logic wrStb;
	logic rdStb;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport bus(output wrStb, rdStb, addr, wdata, input rdata);
	modport core(input wrStb, rdStb, addr, wdata, output rdata);
endinterface

// File: ssp_rate_gen.sv
`timescale 1ns/1ps
/*
 * master bit-rate divider: one-cycle pulse per half serial clock.
 * assumes periodTick is a one-cycle pulse from the period timer.
 */
module ssp_rate_gen
	import ssp_pkg::*;
(
	input logic clk,
	input logic sys_rst,
	input logic run,
	input logic [1:0] sel,
	input logic periodTick,
	output logic halfTick
);
	ssp_rate_t q, d;
	logic [5:0] lim;

	always_comb begin
		d = q;
		halfTick = 1'b0;
		if (sel == RATE_M16) begin
			lim = HALF_DIV16 - 6'h01;
		end else if (sel == RATE_M64) begin
			lim = HALF_DIV64 - 6'h01;
		end else begin
			lim = HALF_DIV4 - 6'h01;
		end
		// restart from zero so every divider-rate transfer gets full first half
		if (!run) begin
			d.cnt = '0;
		end else if (sel == RATE_TMR) begin
			halfTick = periodTick;
		end else if (q.cnt == lim) begin
			d.cnt = '0;
			halfTick = 1'b1;
		end else begin
			d.cnt = q.cnt + 6'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule

// File: ssp_ahb_slave.sv
`timescale 1ns/1ps
/*
 * AHB-Lite slave front end: writes take no wait state, reads
 * take one so hrdata comes from a flop. only word singles.
 * assumes the core answers rdata combinationally from addr.
 */
module ssp_ahb_slave
	import ssp_pkg::*;
(
	input logic clk,
	input logic sys_rst,
	input logic hsel,
	input logic [31:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [2:0] hsize,
	input logic [31:0] hwdata,
	input logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	ssp_reg_if.bus regs
);
	ssp_ahb_t q, d;

	always_comb begin
		d = q;
		case (q.ph)
		AP_WR: begin
			d.ph = AP_IDLE;
		end
		AP_RD: begin
			d.rdata = {24'h00_0000, regs.rdata};
			d.ph = AP_RDOUT;
		end
		AP_RDOUT: begin
			d.ph = AP_IDLE;
		end
		default: begin
		end
		endcase
		if (hready && hsel && htrans == HTRANS_NONSEQ) begin
			d.addr = haddr[7:0];
			d.ph = hwrite ? AP_WR : AP_RD;
		end
	end

	assign regs.wrStb = (q.ph == AP_WR);
	assign regs.rdStb = (q.ph == AP_RD);
	assign regs.addr = q.addr;
	assign regs.wdata = hwdata[7:0];
	assign hreadyout = (q.ph != AP_RD);
	assign hresp = HRESP_OKAY;
	assign hrdata = q.rdata;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule

// File: ssp_top.sv
`timescale 1ns/1ps
/*
 * four-wire serial port core: control and status registers,
 * 8-bit shift register, receive buffer, master clock generation
 * and slave clocking from the pin.
 * assumes serial pins are synchronous to clk; a slave clock must
 * stay well below clk/4 so both edges are seen.
 */

// What this block does
// - one shift register swaps a byte each way, MSB first
// - full byte goes to buffer, then buffer-full and irq flags set
// - next byte may shift in while buffer still unread
// - buffer write during transfer is dropped and sets collision flag
// - collision flag stays set until software clears it
// - reading the buffer clears buffer-full; flag shows data waiting
// - slave byte completing over unread buffer sets overflow, is lost
// - master mode never sets the overflow flag
// - overflow flag stays set until software clears it
// - enable bit hands clock and data pins to the port in mode codes 0 to 5
// - polarity bit sets clock idle level and drive/sample edges
// - mode codes 0 to 3 pick master rate clk/4, /16, /64, timer/2
// - code 4 is slave with select, code 5 slave without
// - two-wire mode codes leave the shift logic idle
// - master drives the clock pin, slave takes it as input
// - top two status bits always read zero
// - master buffer write starts a transfer at once
// - with select high slave output floats and byte pauses
// - slave sets irq flag when last bit is latched
module ssp_top
	import ssp_pkg::*;
(
	input logic clk,
	input logic sys_rst,
	input logic hsel,
	input logic [31:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [2:0] hsize,
	input logic [31:0] hwdata,
	input logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input logic periodTick,
	input logic sckIn,
	output logic sckOut,
	output logic sckOe,
	input logic sdi,
	output logic sdoOut,
	output logic sdoOe,
	input logic ssN,
	output logic portPinsOwned,
	output logic ssPinOwned
);
	localparam ssp_core_t CORE_RESET = '0;

	ssp_reg_if regIf ();
	ssp_core_t q, d;

	logic tick;
	logic runRate;
	logic own;
	logic master;
	logic slave;
	logic ssHold;
	logic rise;
	logic fall;
	logic txEdge;
	logic rxEdge;
	logic busy;
	logic wrCtl;
	logic wrBuf;
	logic wrIrq;
	logic rdBuf;
	logic done;
	logic [7:0] nextSh;

	ssp_ahb_slave u_bus (
		.clk(clk),
		.sys_rst(sys_rst),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.regs(regIf)
	);

	assign runRate = master && (q.mst != MS_IDLE);

	ssp_rate_gen u_rate (
		.clk(clk),
		.sys_rst(sys_rst),
		.run(runRate),
		.sel(q.mode[1:0]),
		.periodTick(periodTick),
		.halfTick(tick)
	);

	always_comb begin
		d = q;
		// two-wire codes fall outside both sets: port stays off
		own = q.en && (isMaster(q.mode) || isSlave(q.mode));
		master = own && isMaster(q.mode);
		slave = own && isSlave(q.mode);
		ssHold = slave && (q.mode == MODE_SL_SS) && ssN;
		rise = sckIn && !q.sckPrev;
		fall = !sckIn && q.sckPrev;
		txEdge = q.clock_polarity_bit ? fall : rise;
		rxEdge = q.clock_polarity_bit ? rise : fall;
		busy = master ? (q.mst != MS_IDLE) : (q.bitCnt != '0);
		wrCtl = regIf.wrStb && (regIf.addr == OFS_CONTROL);
		wrBuf = regIf.wrStb && (regIf.addr == OFS_BUFFER);
		wrIrq = regIf.wrStb && (regIf.addr == OFS_IRQ);
		rdBuf = regIf.rdStb && (regIf.addr == OFS_BUFFER);
		nextSh = {q.shreg[SHIFT_MSB-1:0], sdi};
		done = 1'b0;
		d.sckPrev = sckIn;

		// software writes first so hardware sets below win
		if (wrCtl) begin
			d.write_collision_flag = regIf.wdata[CTL_WRITE_COLLISION_FLAG];
			d.ov = regIf.wdata[CTL_OV];
			d.en = regIf.wdata[CTL_EN];
			d.clock_polarity_bit = regIf.wdata[CTL_CKP];
			d.mode = regIf.wdata[CTL_MODE_MSB:0];
		end
		if (wrBuf) begin
			if (busy) begin
				d.write_collision_flag = 1'b1;
			end else begin
				d.shreg = regIf.wdata;
				if (master) begin
					d.mst = MS_LEAD;
				end
			end
		end
		if (wrIrq) begin
			d.irq = q.irq & regIf.wdata[IRQ_FLAG];
		end
		if (rdBuf) begin
			d.bf = 1'b0;
		end

		if (master) begin
			case (q.mst)
			MS_LEAD: begin
				if (tick) begin
					d.sckAct = 1'b1;
					d.outBit = q.shreg[SHIFT_MSB];
					d.mst = MS_TRAIL;
				end
			end
			MS_TRAIL: begin
				if (tick) begin
					d.sckAct = 1'b0;
					d.shreg = nextSh;
					d.bitCnt = q.bitCnt + 3'h1;
					if (q.bitCnt == LAST_BIT) begin
						done = 1'b1;
						d.mst = MS_IDLE;
					end else begin
						d.mst = MS_LEAD;
					end
				end
			end
			default: begin
			end
			endcase
		end else if (slave && !ssHold) begin
			// select high freezes the bit count: resume on same bit
			if (txEdge) begin
				d.outBit = q.shreg[SHIFT_MSB];
			end
			if (rxEdge) begin
				d.shreg = nextSh;
				d.bitCnt = q.bitCnt + 3'h1;
				done = (q.bitCnt == LAST_BIT);
			end
		end

		if (done) begin
			d.irq = 1'b1;
			// a read in this same cycle frees the buffer in time
			if (slave && d.bf) begin
				d.ov = 1'b1;
			end else begin
				d.rxBuf = nextSh;
				d.bf = 1'b1;
			end
		end

		if (!own) begin
			d.mst = MS_IDLE;
			d.bitCnt = '0;
			d.sckAct = 1'b0;
		end
	end

	always_comb begin
		if (regIf.addr == OFS_CONTROL) begin
			regIf.rdata = {q.write_collision_flag, q.ov, q.en, q.clock_polarity_bit, q.mode};
		end else if (regIf.addr == OFS_STATUS) begin
			regIf.rdata = {7'h00, q.bf};
		end else if (regIf.addr == OFS_BUFFER) begin
			regIf.rdata = q.rxBuf;
		end else if (regIf.addr == OFS_IRQ) begin
			regIf.rdata = {7'h00, q.irq};
		end else begin
			regIf.rdata = 8'h00;
		end
	end

	// idle level follows polarity even while no transfer runs
	assign sckOut = q.clock_polarity_bit ^ q.sckAct;
	assign sckOe = master;
	assign sdoOut = q.outBit;
	assign sdoOe = master || (slave && !ssHold);
	assign portPinsOwned = own;
	assign ssPinOwned = own && (q.mode == MODE_SL_SS);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q <= CORE_RESET;
		end else begin
			q <= d;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sequence bufStart;
		wrBuf && master && (q.mst == MS_IDLE);
	endsequence

	sequence leadTick;
		master && (q.mst == MS_LEAD) && tick;
	endsequence

	chk_start_load: assert property (
		bufStart |=> (q.mst == MS_LEAD) &&
			(q.shreg == $past(regIf.wdata)))
		else $error("buffer write did not start master transfer");

	chk_rate_fast: assert property (
		leadTick and (q.mode == MODE_M4) |=>
			!tick ##1 tick)
		else $error("clk/4 rate half period is not two cycles");

	chk_byte_store: assert property (
		done && !(slave && d.bf) |=> q.bf && q.irq &&
			(q.rxBuf == $past(nextSh)))
		else $error("completed byte not stored with flags");

	chk_collide_flag: assert property (
		wrBuf && busy |=> q.write_collision_flag &&
			(q.shreg == $past(d.shreg)) && $stable(q.rxBuf))
		else $error("write during transfer not flagged");

	chk_collide_hold: assert property (
		q.write_collision_flag && !wrCtl |=> q.write_collision_flag)
		else $error("collision flag cleared by hardware");

	chk_read_clear: assert property (
		rdBuf && !done |=> !q.bf)
		else $error("buffer read did not clear full flag");

	chk_slave_ovf: assert property (
		done && slave && q.bf && !rdBuf |=> q.ov &&
			(q.rxBuf == $past(q.rxBuf)))
		else $error("slave overflow not flagged or buffer hit");

	chk_master_noovf: assert property (
		master && !q.ov && !wrCtl |=> !q.ov)
		else $error("overflow set in master mode");

	chk_ovf_hold: assert property (
		q.ov && !wrCtl |=> q.ov)
		else $error("overflow flag cleared by hardware");

	chk_pins_released: assert property (
		!q.en |-> !sckOe && !sdoOe && !portPinsOwned)
		else $error("pins held while port disabled");

	chk_clock_idle: assert property (
		(q.mst == MS_IDLE) |-> (sckOut == q.clock_polarity_bit))
		else $error("serial clock not at idle level");

	chk_slave_busy: assert property (
		slave && !ssHold && rxEdge && q.bf && !done |=>
			q.bitCnt == $past(q.bitCnt) + 3'h1)
		else $error("reception stalled by full buffer");

	chk_select_float: assert property (
		ssHold |-> !sdoOe ##1 (q.bitCnt == $past(q.bitCnt)))
		else $error("slave active while deselected");

	chk_clock_dir: assert property (
		slave |-> !sckOe)
		else $error("slave drives serial clock");

	chk_abort_clear: assert property (
		!own |=> (q.bitCnt == '0) && (q.mst == MS_IDLE))
		else $error("disabled port kept transfer state");

	chk_eight_bits: assert property (
		done && master |-> (q.bitCnt == LAST_BIT)
			##1 (q.mst == MS_IDLE) && !q.sckAct)
		else $error("master byte did not end after eight clocks");

	chk_status_top: assert property (
		(regIf.addr == OFS_STATUS) |-> (regIf.rdata[7:6] == 2'h0))
		else $error("status top bits not zero");
endmodule

// File: ssp_peer_model.sv
`timescale 1ns/1ps
/*
 * far side of the serial link: shift peer while the port is master,
 * clock-making master while the port is slave.
 * assumes clk is the port's clock and ckp matches the port's setting.
 */
module ssp_peer_model(
	input wire logic clk,
	input wire logic clock_polarity_bit,
	input wire logic sckOut,
	input wire logic sckOe,
	input wire logic sdoOut,
	input wire logic sdoOe,
	output logic sckIn,
	output logic sdi,
	output logic ssN
);
	logic [7:0] txByte = 8'h00;
	logic [7:0] rxByte = 8'h00;
	int edges = 0;
	time lastEdge = 0;
	time halfNs = 0;
	logic pauseOe = 1'b1;
	logic busy = 1'b0;
	initial begin
		sckIn = 1'b0;
		sdi = 1'b0;
		ssN = 1'b1;
	end
	// between frames the clock parks; data keeps toggling while the port is not master so no stale bit
	always @(posedge clk) begin
		if (!busy) begin
			sckIn <= clock_polarity_bit;
			if (!sckOe)
				sdi <= ~sdi;
		end
	end
	always @(sckOut) begin
		if (sckOe) begin
			edges++;
			halfNs = $time - lastEdge;
			lastEdge = $time;
			if (sckOut !== clock_polarity_bit) begin
				sdi <= txByte[7];
				txByte <= {txByte[6:0], txByte[7]};
			end else begin
				rxByte <= {rxByte[6:0], sdoOut};
			end
		end
	end
	task automatic xfer(input logic [7:0] b, input bit pause);
		busy = 1'b1;
		@(posedge clk) ssN <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			if (pause && i == 3) begin
				@(posedge clk) ssN <= 1'b1;
				repeat (4) @(posedge clk);
				pauseOe = sdoOe;
				sckIn <= ~clock_polarity_bit;
				repeat (4) @(posedge clk);
				sckIn <= clock_polarity_bit;
				repeat (4) @(posedge clk);
				ssN <= 1'b0;
			end
			@(posedge clk) sdi <= b[i];
			repeat (4) @(posedge clk);
			sckIn <= ~clock_polarity_bit;
			repeat (4) @(posedge clk);
			sckIn <= clock_polarity_bit;
			rxByte <= {rxByte[6:0], sdoOut};
		end
		repeat (4) @(posedge clk);
		ssN <= 1'b1;
		busy = 1'b0;
	endtask
endmodule

// File: ssp_tb_top.sv
`timescale 1ns/1ps
/*
 * self-checking bench: register traffic over AHB-Lite, master and
 * slave transfers against the partner model.
 * assumes one bus slave, so hready is looped back from hreadyout.
 */
module ssp_tb_top import ssp_pkg::*;;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic periodTick = 1'b0;
	logic clock_polarity_bit = 1'b0;
	logic [2:0] tickCnt = 3'h0;
	logic hreadyout, hresp, sckIn, sckOut, sckOe, sdi, sdoOut, sdoOe, ssN;
	logic portPinsOwned, ssPinOwned;
	logic [31:0] hrdata, pins;
	logic [7:0] tx, rep;
	logic [3:0] twoWire [5] = '{4'h6, 4'h7, 4'hB, 4'hE, 4'hF};
	int halfCyc [4] = '{2, 8, 32, 5};
	int numErrors = 0;
	int nCompared = 0;
	assign pins = {26'h000_0000, hresp, sckOe, sckOut, sdoOe,
		portPinsOwned, ssPinOwned};
	ssp_top dut(.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .periodTick(periodTick), .sckIn(sckIn),
		.sckOut(sckOut), .sckOe(sckOe), .sdi(sdi), .sdoOut(sdoOut),
		.sdoOe(sdoOe), .ssN(ssN), .portPinsOwned(portPinsOwned),
		.ssPinOwned(ssPinOwned));
	ssp_peer_model peer(.clk(clk), .clock_polarity_bit(clock_polarity_bit), .sckOut(sckOut),
		.sckOe(sckOe), .sdoOut(sdoOut), .sdoOe(sdoOe), .sckIn(sckIn),
		.sdi(sdi), .ssN(ssN));
	initial begin
		forever #25 clk = ~clk;
	end
	// timer tick every fifth clock gives a 250 ns half period in mode 3
	always @(posedge clk) begin
		tickCnt <= (tickCnt == 3'h4) ? 3'h0 : tickCnt + 3'h1;
		periodTick <= (tickCnt == 3'h4);
	end
	task automatic completeRun();
		if (numErrors == 0 && nCompared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nCompared++;
		if (got !== exp) begin
			numErrors++;
			$display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [7:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h00_0000, wd};
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] v;
		bus(1'b1, a, d, v);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [31:0] v;
		bus(1'b0, a, 8'h00, v);
		chk(v, {24'h00_0000, e});
	endtask
	task automatic waitBf();
		logic [31:0] v;
		v = 32'h0000_0000;
		for (int n = 0; n < 400 && v[STS_BF] !== 1'b1; n++)
			bus(1'b0, OFS_STATUS, 8'h00, v);
		chk(v, 32'h0000_0001);
	endtask
	function automatic logic [7:0] ctl(input logic en, input logic c,
		input logic [3:0] m);
		return {2'h0, en, c, m};
	endfunction
	initial begin
		repeat (20000) @(posedge clk);
		numErrors++;
		completeRun();
	end
	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		chk(pins, 32'h0000_0000);
		rdc(OFS_CONTROL, 8'h00);
		rdc(OFS_STATUS, 8'h00);
		wr(8'h20, 8'hFF);
		rdc(8'h20, 8'h00);
		rdc(OFS_CONTROL, 8'h00);
		for (int m = 0; m < 4; m++) begin
			clock_polarity_bit <= m[0];
			tx = 8'hC5 ^ 8'(m);
			rep = 8'h3A ^ 8'(m << 4);
			wr(OFS_CONTROL, ctl(1'b1, m[0], 4'(m)));
			repeat (2) @(posedge clk);
			chk(pins, {26'h000_0000, 2'h1, m[0], 3'h6});
			peer.txByte = rep;
			peer.edges = 0;
			wr(OFS_BUFFER, tx);
			wr(OFS_BUFFER, 8'hFF);
			waitBf();
			chk(32'(peer.rxByte), 32'(tx));
			chk(32'(peer.edges), 32'h0000_0010);
			chk(32'(peer.halfNs), 32'(halfCyc[m] * 50));
			chk(pins, {26'h000_0000, 2'h1, m[0], 3'h6});
			rdc(OFS_CONTROL, ctl(1'b1, m[0], 4'(m)) | 8'h80);
			rdc(OFS_IRQ, 8'h01);
			wr(OFS_IRQ, 8'h00);
			rdc(OFS_IRQ, 8'h00);
			rdc(OFS_BUFFER, rep);
			rdc(OFS_STATUS, 8'h00);
		end
		clock_polarity_bit <= 1'b0;
		foreach (twoWire[i]) begin
			wr(OFS_CONTROL, ctl(1'b1, 1'b0, twoWire[i]));
			repeat (2) @(posedge clk);
			peer.edges = 0;
			wr(OFS_BUFFER, 8'h55);
			repeat (40) @(posedge clk);
			chk(pins, 32'h0000_0000);
			chk(32'(peer.edges), 32'h0000_0000);
			rdc(OFS_STATUS, 8'h00);
		end
		wr(OFS_CONTROL, ctl(1'b1, 1'b0, MODE_M64));
		wr(OFS_BUFFER, 8'h11);
		repeat (100) @(posedge clk);
		wr(OFS_CONTROL, 8'h00);
		repeat (2) @(posedge clk);
		chk(pins, 32'h0000_0000);
		rdc(OFS_STATUS, 8'h00);
		wr(OFS_CONTROL, ctl(1'b1, 1'b0, MODE_M4));
		peer.txByte = 8'h69;
		peer.edges = 0;
		wr(OFS_BUFFER, 8'hB4);
		waitBf();
		chk(32'(peer.rxByte), 32'h0000_00B4);
		chk(32'(peer.edges), 32'h0000_0010);
		rdc(OFS_BUFFER, 8'h69);
		wr(OFS_CONTROL, ctl(1'b1, 1'b0, MODE_SL));
		wr(OFS_BUFFER, 8'hE7);
		peer.xfer(8'h5B, 1'b0);
		chk(32'(peer.rxByte), 32'h0000_00E7);
		chk(pins, 32'h0000_0006);
		rdc(OFS_STATUS, 8'h01);
		rdc(OFS_IRQ, 8'h01);
		peer.xfer(8'hC3, 1'b0);
		rdc(OFS_CONTROL, 8'h65);
		rdc(OFS_BUFFER, 8'h5B);
		rdc(OFS_CONTROL, 8'h65);
		wr(OFS_CONTROL, 8'h25);
		peer.xfer(8'h7E, 1'b0);
		rdc(OFS_BUFFER, 8'h7E);
		rdc(OFS_CONTROL, 8'h25);
		wr(OFS_CONTROL, 8'h00);
		clock_polarity_bit <= 1'b1;
		repeat (3) @(posedge clk);
		wr(OFS_CONTROL, ctl(1'b1, 1'b1, MODE_SL_SS));
		repeat (2) @(posedge clk);
		chk(pins, 32'h0000_000B);
		wr(OFS_BUFFER, 8'h2D);
		peer.xfer(8'hD2, 1'b1);
		chk(32'(peer.pauseOe), 32'h0000_0000);
		chk(32'(peer.rxByte), 32'h0000_002D);
		rdc(OFS_BUFFER, 8'hD2);
		completeRun();
	end
endmodule
